//--- pkg/mise_pkg.sv
// Purpose: Shared constants and types for the instruction subset executor
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file addresses
// Notes:   Behaviour list below, implemented in the design files
//
// Behaviour
// - Return pops stack, loads top into PC
// - Return takes two cycles, one word
// - Rotate right through carry, carry only
// - Rotate left through carry, carry only
// - Destination bit 0 to W, 1 to file
// - Nibble swap, steered result, flags untouched
// - XOR literal into W, zero flag only
// - XOR file with W, steered, zero only
// - Sleep clears watchdog, sets timeout, clears powerdown
// - Sleep halts oscillator, core sleeps
// - Direction registers also plain file registers; here only the direction load drives o_dir_we
package mise_pkg;

  localparam int          PC_W          = 13;
  localparam int          RETURN_CYCLES = 2;

  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [13:0] OPC_RETURN    = 14'h0008;
  localparam logic [13:0] OPC_SLEEP     = 14'h0063;
  localparam logic [10:0] OPC_DIR_LOAD  = 11'h00C;
  localparam logic [3:0]  OPC_BIT_CLR   = 4'h4;
  localparam logic [3:0]  OPC_BIT_SET   = 4'h5;
  localparam logic [3:0]  OPC_BIT_TEST  = 4'h6;
  localparam logic [5:0]  OPC_ROT_RIGHT = 6'h0C;
  localparam logic [5:0]  OPC_ROT_LEFT  = 6'h0D;
  localparam logic [5:0]  OPC_SWAP      = 6'h0E;
  localparam logic [5:0]  OPC_XOR_FILE  = 6'h06;
  localparam logic [5:0]  OPC_XOR_LIT   = 6'h3A;
  localparam logic [2:0]  DIR_SEL_MIN   = 3'h5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int          DEST_BIT      = 7;
  localparam int          BSEL_LSB      = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  W_RST         = 8'h00;
  localparam logic        TO_RST        = 1'b1;
  localparam logic        PD_RST        = 1'b1;

  typedef enum logic [3:0] {
    OP_NONE      = 4'b0000,
    OP_BIT_CLR   = 4'b0001,
    OP_BIT_SET   = 4'b0010,
    OP_BIT_TEST  = 4'b0011,
    OP_ROT_RIGHT = 4'b0100,
    OP_ROT_LEFT  = 4'b0101,
    OP_SWAP      = 4'b0110,
    OP_XOR_FILE  = 4'b0111,
    OP_XOR_LIT   = 4'b1000,
    OP_RETURN    = 4'b1001,
    OP_DIR_LOAD  = 4'b1010,
    OP_SLEEP     = 4'b1011
  } mise_op_type;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRAIN = 2'b01,
    ST_SLEEP = 2'b10
  } mise_state_type;

endpackage : mise_pkg

//--- pkg/mise_alu_if.sv
// Purpose: Carrier between the executor and its data path
// Assumes: Purely combinational exchange on one clock
// Notes:   Core drives operands, data path returns result
`timescale 1ns/100ps
interface mise_alu_if;
  import mise_pkg::*;

  mise_op_type op;
  logic [7:0]  file_val;
  logic [7:0]  w;
  logic [7:0]  literal;
  logic [2:0]  bit_sel;
  logic        carry_in;
  logic [7:0]  result;
  logic        carry_out;
  logic        zero_out;
  logic        skip;

  modport core (output op, file_val, w, literal, bit_sel, carry_in,
                input  result, carry_out, zero_out, skip);
  modport alu  (input  op, file_val, w, literal, bit_sel, carry_in,
                output result, carry_out, zero_out, skip);
endinterface : mise_alu_if

//--- hw/mise_alu.sv
// Purpose: Result, carry, zero and skip for the executed subset
// Assumes: Operands stable in the cycle of execution
// Notes:   No state; core decides where results go
`timescale 1ns/100ps
module mise_alu (
  mise_alu_if.alu alu_port
);
  import mise_pkg::*;

  always_comb begin
    alu_port.result    = alu_port.file_val;
    alu_port.carry_out = alu_port.carry_in;
    alu_port.skip      = 1'b0;
    case (alu_port.op)
      OP_BIT_CLR: begin
        alu_port.result = alu_port.file_val & ~(8'h01 << alu_port.bit_sel);
      end
      OP_BIT_SET: begin
        alu_port.result = alu_port.file_val | (8'h01 << alu_port.bit_sel);
      end
      OP_BIT_TEST: begin
        alu_port.skip = ~alu_port.file_val[alu_port.bit_sel];
      end
      OP_ROT_RIGHT: begin
        alu_port.result    = {alu_port.carry_in, alu_port.file_val[7:1]};
        alu_port.carry_out = alu_port.file_val[0];
      end
      OP_ROT_LEFT: begin
        alu_port.result    = {alu_port.file_val[6:0], alu_port.carry_in};
        alu_port.carry_out = alu_port.file_val[7];
      end
      OP_SWAP: begin
        alu_port.result = {alu_port.file_val[3:0], alu_port.file_val[7:4]};
      end
      OP_XOR_FILE: begin
        alu_port.result = alu_port.file_val ^ alu_port.w;
      end
      OP_XOR_LIT: begin
        alu_port.result = alu_port.w ^ alu_port.literal;
      end
      default: begin
        alu_port.result = alu_port.file_val;
      end
    endcase
    alu_port.zero_out = (alu_port.result == 8'h00);
  end

endmodule : mise_alu

//--- hw/mise_exec.sv
// Purpose: Decode and execute a subset of the 14-bit instruction set
// Assumes: File read data combinational on o_file_raddr, same clock
// Notes:   Writes land one cycle after the instruction is taken
`timescale 1ns/100ps
module mise_exec (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_instr_valid,
  input  wire logic [13:0]              i_instr,
  input  wire logic [7:0]               i_file_rdata,
  input  wire logic [mise_pkg::PC_W-1:0] i_stack_top,
  input  wire logic                     i_wake,
  output logic                          o_ready,
  output logic                          o_flush,
  output logic [6:0]                    o_file_raddr,
  output logic                          o_file_we,
  output logic [6:0]                    o_file_addr,
  output logic [7:0]                    o_file_wdata,
  output logic [7:0]                    o_w,
  output logic                          o_carry,
  output logic                          o_zero,
  output logic                          o_timeout_flag,
  output logic                          o_power_down_flag,
  output logic                          o_stack_pop,
  output logic                          o_pc_load,
  output logic [mise_pkg::PC_W-1:0]     o_pc_value,
  output logic                          o_dir_we,
  output logic [2:0]                    o_dir_sel,
  output logic [7:0]                    o_dir_data,
  output logic                          o_wdt_clear,
  output logic                          o_sleep,
  output logic                          o_osc_halt
);
  import mise_pkg::*;

  typedef struct packed {
    mise_state_type  st;
    logic [7:0]      w;
    logic            carry;
    logic            zero;
    logic            to;
    logic            pd;
    logic            file_we;
    logic [6:0]      file_addr;
    logic [7:0]      file_wdata;
    logic            pc_load;
    logic            stack_pop;
    logic [PC_W-1:0] pc_value;
    logic            dir_we;
    logic [2:0]      dir_sel;
    logic [7:0]      dir_data;
    logic            wdt_clear;
  } mise_regs_type;

  localparam mise_regs_type REGS_RST = '{
    st: ST_RUN, w: W_RST, carry: 1'b0, zero: 1'b0, to: TO_RST, pd: PD_RST,
    file_we: 1'b0, file_addr: 7'h00, file_wdata: 8'h00, pc_load: 1'b0,
    stack_pop: 1'b0, pc_value: '0, dir_we: 1'b0, dir_sel: 3'h0,
    dir_data: 8'h00, wdt_clear: 1'b0};

  mise_regs_type q;
  mise_regs_type d;
  mise_op_type   op;
  logic          take;
  logic          wr_dest;
  logic [7:0]    fval;
  logic [2:0]    bsel;
  mise_alu_if    u_if ();

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    op = OP_NONE;
    if (i_instr == OPC_RETURN) begin
      op = OP_RETURN;
    end else if (i_instr == OPC_SLEEP) begin
      op = OP_SLEEP;
    end else if (i_instr[13:3] == OPC_DIR_LOAD) begin
      op = OP_DIR_LOAD;
    end else if (i_instr[13:10] == OPC_BIT_CLR) begin
      op = OP_BIT_CLR;
    end else if (i_instr[13:10] == OPC_BIT_SET) begin
      op = OP_BIT_SET;
    end else if (i_instr[13:10] == OPC_BIT_TEST) begin
      op = OP_BIT_TEST;
    end else if (i_instr[13:8] == OPC_ROT_RIGHT) begin
      op = OP_ROT_RIGHT;
    end else if (i_instr[13:8] == OPC_ROT_LEFT) begin
      op = OP_ROT_LEFT;
    end else if (i_instr[13:8] == OPC_SWAP) begin
      op = OP_SWAP;
    end else if (i_instr[13:8] == OPC_XOR_FILE) begin
      op = OP_XOR_FILE;
    end else if (i_instr[13:8] == OPC_XOR_LIT) begin
      op = OP_XOR_LIT;
    end
  end

  assign o_ready      = (q.st == ST_RUN);
  assign take         = i_instr_valid && o_ready;
  assign bsel         = i_instr[BSEL_LSB+2:BSEL_LSB];
  assign o_file_raddr = i_instr[6:0];
  // Forward a pending write so back-to-back ops on one address see it
  assign fval         = (q.file_we && (q.file_addr == i_instr[6:0])) ? q.file_wdata : i_file_rdata;

  assign u_if.op       = op;
  assign u_if.file_val = fval;
  assign u_if.w        = q.w;
  assign u_if.literal  = i_instr[7:0];
  assign u_if.bit_sel  = bsel;
  assign u_if.carry_in = q.carry;

  mise_alu u_alu (
    .alu_port (u_if.alu)
  );

  // Fetch must drop its prefetched word on a taken return or skip
  assign o_flush = take && ((op == OP_RETURN) || ((op == OP_BIT_TEST) && u_if.skip));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d           = q;
    d.file_we   = 1'b0;
    d.pc_load   = 1'b0;
    d.stack_pop = 1'b0;
    d.dir_we    = 1'b0;
    d.wdt_clear = 1'b0;
    wr_dest     = 1'b0;
    case (q.st)
      ST_RUN: begin
        if (take) begin
          case (op)
            OP_BIT_CLR, OP_BIT_SET: begin
              d.file_we    = 1'b1;
              d.file_addr  = i_instr[6:0];
              d.file_wdata = u_if.result;
            end
            OP_BIT_TEST: begin
              if (u_if.skip) begin
                d.st = ST_DRAIN;
              end
            end
            OP_ROT_RIGHT, OP_ROT_LEFT: begin
              d.carry = u_if.carry_out;
              wr_dest = 1'b1;
            end
            OP_SWAP: begin
              wr_dest = 1'b1;
            end
            OP_XOR_FILE: begin
              d.zero  = u_if.zero_out;
              wr_dest = 1'b1;
            end
            OP_XOR_LIT: begin
              d.w    = u_if.result;
              d.zero = u_if.zero_out;
            end
            OP_RETURN: begin
              d.stack_pop = 1'b1;
              d.pc_load   = 1'b1;
              d.pc_value  = i_stack_top;
              d.st        = ST_DRAIN;
            end
            OP_DIR_LOAD: begin
              // Selectors below 5 name no direction register and are ignored
              d.dir_we   = (i_instr[2:0] >= DIR_SEL_MIN);
              d.dir_sel  = i_instr[2:0];
              d.dir_data = q.w;
            end
            OP_SLEEP: begin
              d.wdt_clear = 1'b1;
              d.to        = 1'b1;
              d.pd        = 1'b0;
              d.st        = ST_SLEEP;
            end
            default: begin
              d.st = ST_RUN;
            end
          endcase
        end
      end
      ST_DRAIN: begin
        d.st = ST_RUN;
      end
      ST_SLEEP: begin
        if (i_wake) begin
          d.st = ST_RUN;
        end
      end
      default: begin
        d.st = ST_RUN;
      end
    endcase
    if (wr_dest) begin
      if (i_instr[DEST_BIT]) begin
        // Result goes to the addressed file register; o_dir_we is set only by a direction load
        d.file_we    = 1'b1;
        d.file_addr  = i_instr[6:0];
        d.file_wdata = u_if.result;
      end else begin
        d.w = u_if.result;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_file_we         = q.file_we;
  assign o_file_addr       = q.file_addr;
  assign o_file_wdata      = q.file_wdata;
  assign o_w               = q.w;
  assign o_carry           = q.carry;
  assign o_zero            = q.zero;
  assign o_timeout_flag    = q.to;
  assign o_power_down_flag = q.pd;
  assign o_stack_pop       = q.stack_pop;
  assign o_pc_load         = q.pc_load;
  assign o_pc_value        = q.pc_value;
  assign o_dir_we          = q.dir_we;
  assign o_dir_sel         = q.dir_sel;
  assign o_dir_data        = q.dir_data;
  assign o_wdt_clear       = q.wdt_clear;
  assign o_sleep           = (q.st == ST_SLEEP);
  assign o_osc_halt        = (q.st == ST_SLEEP);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_return_pop_load: assert property (take && op == OP_RETURN |=>
    o_stack_pop && o_pc_load && o_pc_value == $past(i_stack_top) && $stable(o_carry) && $stable(o_zero))
    else $error("return did not pop and load");
  a_return_two_cyc: assert property (take && op == OP_RETURN |-> o_flush ##1 !o_ready ##1 o_ready)
    else $error("return not two cycles");
  a_rotate_right: assert property (take && op == OP_ROT_RIGHT && !i_instr[DEST_BIT] |=>
    o_w == {$past(o_carry), $past(fval[7:1])} && o_carry == $past(fval[0]) && $stable(o_zero))
    else $error("rotate right wrong");
  a_rotate_left: assert property (take && op == OP_ROT_LEFT && !i_instr[DEST_BIT] |=>
    o_w[7:1] == $past(fval[6:0]) && o_w[0] == $past(o_carry) && o_carry == $past(fval[7]))
    else $error("rotate left wrong");
  a_dest_to_file: assert property (take && wr_dest && i_instr[DEST_BIT] |=>
    o_file_we && o_file_addr == $past(o_file_raddr) && $stable(o_w))
    else $error("file destination not written");
  a_swap_no_flags: assert property (take && op == OP_SWAP && !i_instr[DEST_BIT] |=>
    o_w == {$past(fval[3:0]), $past(fval[7:4])} && $stable(o_carry) && $stable(o_zero))
    else $error("swap wrong");
  a_xor_literal: assert property (take && op == OP_XOR_LIT |=>
    o_w == ($past(o_w) ^ $past(u_if.literal)) && o_zero == (o_w == 8'h00) && $stable(o_carry))
    else $error("xor literal wrong");
  a_xor_file_zero: assert property (take && op == OP_XOR_FILE |=>
    o_zero == (($past(fval) ^ $past(o_w)) == 8'h00) && $stable(o_carry))
    else $error("xor file zero wrong");
  a_sleep_flags: assert property (take && op == OP_SLEEP |=>
    o_wdt_clear && o_timeout_flag && !o_power_down_flag)
    else $error("sleep flags wrong");
  a_sleep_halt: assert property (take && op == OP_SLEEP |=> o_osc_halt && !o_ready)
    else $error("sleep did not halt");
  a_dir_load: assert property (take && op == OP_DIR_LOAD |=>
    o_dir_we == ($past(i_instr[2:0]) >= DIR_SEL_MIN) && o_dir_sel == $past(i_instr[2:0]) &&
    o_dir_data == $past(o_w) && $stable(o_carry) && $stable(o_zero))
    else $error("direction load wrong");
  a_skip_clear: assert property (take && op == OP_BIT_TEST && !fval[bsel] |-> o_flush ##1 !o_ready)
    else $error("skip not taken");
  a_bit_set_one: assert property (take && op == OP_BIT_SET |=>
    o_file_we && o_file_wdata[$past(bsel)] && $stable(o_carry))
    else $error("bit set wrong");
  a_bit_clear_zero: assert property (take && op == OP_BIT_CLR |=>
    o_file_we && !o_file_wdata[$past(bsel)] && $stable(o_carry) && $stable(o_zero))
    else $error("bit clear wrong");

endmodule : mise_exec

//--- dv/tb_mcu_instruction_subset_exec.sv
// Purpose: Self-checking bench for the instruction subset executor
// Assumes: File memory and stack top modelled here; one 125 MHz clock
// Notes:   Reference model runs ahead of the take edge, file writes land after it
`timescale 1ns/100ps
module tb_mcu_instruction_subset_exec;
  import mise_pkg::*;

  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic            i_mclk        = 1'b0;
  logic            i_rstn        = 1'b0;
  logic            i_instr_valid = 1'b0;
  logic            i_wake        = 1'b0;
  logic [13:0]     i_instr       = 14'h0000;
  logic [PC_W-1:0] i_stack_top   = '0;
  logic [7:0]      i_file_rdata;
  logic            o_ready, o_flush, o_file_we, o_carry, o_zero, o_timeout_flag, o_power_down_flag;
  logic            o_stack_pop, o_pc_load, o_dir_we, o_wdt_clear, o_sleep, o_osc_halt;
  logic [6:0]      o_file_raddr, o_file_addr;
  logic [7:0]      o_file_wdata, o_w, o_dir_data;
  logic [2:0]      o_dir_sel;
  logic [PC_W-1:0] o_pc_value;
  // Bench file memory and reference state
  logic [7:0]      mem [0:127];
  logic [7:0]      mw, edata;
  logic            mc, mz, mto, mpd, ewe, edir, epop, eflush, esleep;
  logic [6:0]      eaddr;
  logic [2:0]      esel;
  logic [31:0]     seed = 32'h0001_5D0C;
  int              mismatches = 0;
  int              tests_run = 0;
  logic [13:0]     base [0:8] = '{14'h1000, 14'h0C00, 14'h0D00, 14'h0E00, 14'h0600, 14'h3A00, 14'h0008,
                                   14'h0060, 14'h0700};
  logic [13:0]     mask [0:8] = '{14'h0FFF, 14'h00FF, 14'h00FF, 14'h00FF, 14'h00FF, 14'h00FF, 14'h0000,
                                   14'h0007, 14'h00FF};

  always #4 i_mclk = ~i_mclk;
  assign i_file_rdata = mem[o_file_raddr];

  mise_exec dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_file_rdata(i_file_rdata), .i_stack_top(i_stack_top), .i_wake(i_wake), .o_ready(o_ready),
    .o_flush(o_flush), .o_file_raddr(o_file_raddr), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
    .o_file_wdata(o_file_wdata), .o_w(o_w), .o_carry(o_carry), .o_zero(o_zero),
    .o_timeout_flag(o_timeout_flag), .o_power_down_flag(o_power_down_flag), .o_stack_pop(o_stack_pop),
    .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_dir_we(o_dir_we), .o_dir_sel(o_dir_sel),
    .o_dir_data(o_dir_data), .o_wdt_clear(o_wdt_clear), .o_sleep(o_sleep), .o_osc_halt(o_osc_halt)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Async reset held across edges, released just after a rising edge
  task automatic do_reset(input int cycles);
    i_rstn = 1'b0;
    i_instr_valid = 1'b0;
    repeat (cycles) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    {mw, mc, mz, mto, mpd} = {8'h00, 1'b0, 1'b0, 1'b1, 1'b1};
    chk("o_w", o_w, mw);
    chk("o_timeout_flag", o_timeout_flag, 1'b1);
    chk("o_power_down_flag", o_power_down_flag, 1'b1);
    chk("o_ready", o_ready, 1'b1);
  endtask : do_reset

  // ****************************************************************
  // Reference model, evaluated before the take edge
  // ****************************************************************
  task automatic model(input logic [13:0] i);
    logic [7:0] f;
    logic [7:0] r;
    f = mem[i[6:0]];
    r = f;
    {ewe, edir, epop, eflush, esleep} = 5'b00000;
    eaddr = i[6:0];
    esel = i[2:0];
    edata = 8'h00;
    if (i[13:12] == 2'b01 && i[11:10] != 2'b11) begin
      if (i[11:10] == 2'b10) eflush = !f[i[9:7]];
      else begin
        r[i[9:7]] = i[10];
        ewe = 1'b1;
        edata = r;
      end
    end else if (i == 14'h0008) begin
      epop = 1'b1;
      eflush = 1'b1;
    end else if (i == 14'h0063) begin
      {esleep, mto, mpd} = 3'b110;
    end else if (i[13:3] == 11'h00C) edir = (i[2:0] >= 3'h5);
    else if (i[13:8] == 6'h3A) begin
      mw = mw ^ i[7:0];
      mz = (mw == 8'h00);
    end else if (i[13:8] inside {6'h0C, 6'h0D, 6'h0E, 6'h06}) begin
      case (i[13:8])
        6'h0C: {r, mc} = {mc, f};
        6'h0D: {mc, r} = {f, mc};
        6'h0E: r = {f[3:0], f[7:4]};
        default: begin
          r = mw ^ f;
          mz = (r == 8'h00);
        end
      endcase
      if (i[7]) {ewe, edata} = {1'b1, r};
      else mw = r;
    end
  endtask : model

  // One instruction taken at the next edge, results checked one cycle later
  task automatic issue(input logic [13:0] i);
    logic [PC_W-1:0] top;
    model(i);
    top = PC_W'(rnd());
    i_instr = i;
    i_instr_valid = 1'b1;
    i_stack_top = top;
    #1 chk("o_ready", o_ready, 1'b1);
    chk("o_flush", o_flush, eflush);
    @(posedge i_mclk);
    #1 chk("o_file_we", o_file_we, ewe);
    if (ewe) begin
      chk("o_file_addr", o_file_addr, eaddr);
      chk("o_file_wdata", o_file_wdata, edata);
      mem[eaddr] = edata;
    end
    chk("o_w", o_w, mw);
    chk("o_carry", o_carry, mc);
    chk("o_zero", o_zero, mz);
    chk("o_timeout_flag", o_timeout_flag, mto);
    chk("o_power_down_flag", o_power_down_flag, mpd);
    chk("o_dir_we", o_dir_we, edir);
    if (edir) chk("o_dir_data", {o_dir_sel, o_dir_data}, {esel, mw});
    chk("o_stack_pop", {o_stack_pop, o_pc_load}, {epop, epop});
    if (epop) chk("o_pc_value", o_pc_value, top);
    chk("o_wdt_clear", {o_wdt_clear, o_sleep, o_osc_halt}, {3{esleep}});
    if (eflush) begin
      chk("o_ready", o_ready, 1'b0);
      i_instr = 14'h3AFF;
      @(posedge i_mclk);
      #1 chk("o_w", o_w, mw);
    end
  endtask : issue

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    for (int k = 0; k < 128; k++) mem[k] = 8'(rnd());
    @(posedge i_mclk);
    do_reset(5);
    $display("test reset done");
    mem[7'h20] = 8'hC7;
    issue(14'h13A0);
    issue(14'h17A0);
    issue(14'h1BA0);
    issue(14'h13A0);
    issue(14'h1BA0);
    issue(14'h0008);
    issue(14'h0008);
    $display("test bit and return done");
    issue(14'h3A00 | 14'(rnd() & 32'hFF));
    // Selector 3 shares the sleep code, which has its own scenario
    for (int s = 0; s < 8; s++) if (s != 3) issue({11'h00C, 3'(s)});
    $display("test direction done");
    issue(14'h0063);
    repeat (3) begin
      chk("o_ready", o_ready, 1'b0);
      i_instr = 14'h3A55;
      @(posedge i_mclk);
      #1 chk("o_w", o_w, mw);
    end
    i_wake = 1'b1;
    @(posedge i_mclk);
    #1 i_wake = 1'b0;
    chk("o_sleep", {o_sleep, o_ready, o_power_down_flag}, 3'b010);
    $display("test sleep done");
    for (int n = 0; n < 400; n++) begin
      logic [31:0] r;
      logic [13:0] ins;
      r = rnd();
      ins = base[r[7:4] % 9] | (14'(r >> 8) & mask[r[7:4] % 9]);
      // Random runs never wake the core, so keep sleep out of them
      if (ins == 14'h0063) ins = 14'h0067;
      issue(ins);
    end
    $display("test random done");
    do_reset(2);
    issue(14'h0008);
    issue(14'h0C80);
    $display("test second reset done");
    report_and_stop();
  end

  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

endmodule : tb_mcu_instruction_subset_exec
